// [logic/ssr_params.svh]
// Constants of the status and service-request unit.
// Assumes a 100 MHz clock and an APB slave with 32-bit aligned words.
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SSR_A_STB       12'h000
`define SSR_A_POLL      12'h004
`define SSR_A_SRE       12'h008
`define SSR_A_ESR       12'h00C
`define SSR_A_ESE       12'h010
`define SSR_A_QEVT      12'h014
`define SSR_A_QENA      12'h018
`define SSR_A_IEVT      12'h01C
`define SSR_A_IENA      12'h020
`define SSR_A_SEVT1     12'h024
`define SSR_A_SENA1     12'h030
`define SSR_A_COND1     12'h03C
`define SSR_A_ERR       12'h048
`define SSR_A_CMD       12'h04C
`define SSR_A_STAT      12'h050
`define SSR_A_OBUF      12'h054

// ****************************************
// Command codes written to the command register
// ****************************************
`define SSR_CMD_CLS     8'h01
`define SSR_CMD_OPC     8'h02
`define SSR_CMD_RST     8'h03
`define SSR_CMD_STBQ    8'h04
`define SSR_CMD_RESP    8'h05

// ****************************************
// Bit positions
// ****************************************
`define SSR_B_QUES      3
`define SSR_B_MAV       4
`define SSR_B_ESB       5
`define SSR_B_RQS       6
`define SSR_B_OPC       0
`define SSR_B_INSTRUMENT_SUMMARY_BIT      13
`define SSR_ESR_MASK    8'hBD

// ****************************************
// Queue and codes
// ****************************************
`define SSR_QDEPTH      5'h14
`define SSR_QLAST       5'h13
`define SSR_CODE_OVF    16'hFEA2
`define SSR_CODE_NONE   16'h0000
`define SSR_OBUF_DEPTH  4'h8

`endif

// [logic/ssr_pkg.sv]
// Types of the status and service-request unit.
// Assumes ssr_params.svh supplies the numbers.
package ssr_pkg;
   typedef enum logic [2:0] {
      SSR_IDLE  = 3'b001,
      SSR_EXEC  = 3'b010,
      SSR_STALL = 3'b100
   } ssr_state_type;
endpackage : ssr_pkg

// [logic/ssr_unit.sv]
// Status byte, service request, event registers and error queue.
// Assumes an APB master; events and conditions arrive as synchronous levels/pulses.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_params.svh"

module ssr_unit (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Event sources
   input  wire logic [7:0]  std_event_i,
   input  wire logic [15:0] ques_event_i,
   input  wire logic [2:0][15:0] out_event_i,
   input  wire logic [2:0][1:0]  out_cond_i,
   input  wire logic        err_valid_i,
   input  wire logic [15:0] err_code_i,
   input  wire logic        obuf_read_i,
   // Indications
   output logic             service_request_o,
   output logic             error_indicator_o,
   output logic             beep_o,
   output logic             cmd_busy_o
);

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0]       sre;
   logic [7:0]       esr;
   logic [7:0]       ese;
   logic [15:0]      qevt;
   logic [15:0]      qena;
   logic [15:0]      ievt;
   logic [15:0]      iena;
   logic [2:0][15:0] sevt;
   logic [2:0][15:0] sena;
   logic             rqs;
   logic [15:0]      errq [0:19];
   logic [4:0]       q_head;
   logic [4:0]       q_cnt;
   logic             q_lock;
   logic [3:0]       obuf_cnt;
   logic [7:0]       cmd_pend;
   ssr_pkg::ssr_state_type state;

   logic             wr_en;
   logic             rd_en;
   logic             acc;
   logic [7:0]       stb;
   logic [7:0]       esb_src;
   logic [15:0]      ques_full;
   logic [15:0]      inst_full;
   logic             rqs_cond;
   logic             rd_poll;
   logic             rd_esr;
   logic             rd_qevt;
   logic             rd_ievt;
   logic             rd_err;
   logic             do_cls;
   logic             do_opc;
   logic             do_stbq;
   logic             do_resp;
   logic [31:0]      next_rdata;
   logic [1:0]       sel_idx;

   function automatic logic [4:0] wrap_idx(input logic [4:0] a, input logic [4:0] b);
      logic [5:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, `SSR_QDEPTH}) begin
         s = s - {1'b0, `SSR_QDEPTH};
      end
      return s[4:0];
   endfunction : wrap_idx

   function automatic logic [1:0] out_sel(input logic [11:0] a, input logic [11:0] base);
      return 2'((a - base) >> 2);
   endfunction : out_sel

   // ****************************************
   // Bus decode
   // ****************************************
   // Read side effects at the prdata capture edge, so no event is lost
   assign acc     = psel_i && penable_i && pready_o && paddr_i[1:0] == 2'b00;
   assign wr_en   = acc && pwrite_i;
   assign rd_en   = psel_i && penable_i && !pready_o && !pwrite_i && paddr_i[1:0] == 2'b00;
   assign rd_poll = rd_en && paddr_i == `SSR_A_POLL;
   assign rd_esr  = rd_en && paddr_i == `SSR_A_ESR;
   assign rd_qevt = rd_en && paddr_i == `SSR_A_QEVT;
   assign rd_ievt = rd_en && paddr_i == `SSR_A_IEVT;
   assign rd_err  = rd_en && paddr_i == `SSR_A_ERR;
   assign do_cls  = state == ssr_pkg::SSR_EXEC && cmd_pend == `SSR_CMD_CLS;
   assign do_opc  = state == ssr_pkg::SSR_EXEC && cmd_pend == `SSR_CMD_OPC;
   assign do_stbq = state == ssr_pkg::SSR_EXEC && cmd_pend == `SSR_CMD_STBQ;
   assign do_resp = state == ssr_pkg::SSR_EXEC && cmd_pend == `SSR_CMD_RESP;

   // ****************************************
   // Summary logic
   // ****************************************
   always_comb begin
      inst_full = '0;
      for (int i = 0; i < 3; i++) begin
         inst_full[i+1] = |(sevt[i] & sena[i]);
      end
      ques_full = qevt;
      ques_full[`SSR_B_INSTRUMENT_SUMMARY_BIT] = qevt[`SSR_B_INSTRUMENT_SUMMARY_BIT] | (|(ievt & iena));
   end

   assign esb_src = esr & ese;
   always_comb begin
      stb = '0;
      stb[`SSR_B_QUES] = |(ques_full & qena);
      stb[`SSR_B_MAV]  = obuf_cnt != '0;
      stb[`SSR_B_ESB]  = |esb_src;
      stb[`SSR_B_RQS]  = rqs;
   end

   // Rising summary requests service once; reading source drops it
   assign rqs_cond = |(stb & sre & 8'h38);

   // ****************************************
   // Request-service bit
   // ****************************************
   logic rqs_cond_d;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rqs        <= 1'b0;
         rqs_cond_d <= 1'b0;
      end else begin
         rqs_cond_d <= rqs_cond;
         if (rqs_cond && !rqs_cond_d) begin
            rqs <= 1'b1;
         end else if (rd_poll || do_cls || !rqs_cond) begin
            rqs <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         service_request_o <= 1'b0;
      end else begin
         service_request_o <= rqs;
      end
   end

   // ****************************************
   // Enables
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sre  <= '0;
         ese  <= '0;
         qena <= '0;
         iena <= '0;
         sena <= '0;
      end else if (wr_en) begin
         case (paddr_i)
            `SSR_A_SRE:  sre  <= pwdata_i[7:0] & 8'hBF;
            `SSR_A_ESE:  ese  <= pwdata_i[7:0];
            `SSR_A_QENA: qena <= pwdata_i[15:0];
            `SSR_A_IENA: iena <= pwdata_i[15:0];
            default: begin
               if (paddr_i >= `SSR_A_SENA1 && paddr_i < `SSR_A_COND1) begin
                  sena[out_sel(paddr_i, `SSR_A_SENA1)] <= pwdata_i[15:0];
               end
            end
         endcase
      end
   end

   // ****************************************
   // Event registers: set wins over clear
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         esr <= 8'h80;
      end else begin
         esr <= ((rd_esr || do_cls) ? 8'h00 : esr) | (std_event_i & `SSR_ESR_MASK)
                | (do_opc ? 8'h01 : 8'h00);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         qevt <= '0;
         ievt <= '0;
      end else begin
         qevt <= ((rd_qevt || do_cls) ? 16'h0000 : qevt) | ques_event_i;
         ievt <= ((rd_ievt || do_cls) ? 16'h0000 : ievt) | inst_full;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sevt <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if ((rd_en && paddr_i == `SSR_A_SEVT1 + 12'(4 * i)) || do_cls) begin
               sevt[i] <= out_event_i[i];
            end else begin
               sevt[i] <= sevt[i] | out_event_i[i];
            end
         end
      end
   end

   // ****************************************
   // Error queue
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i || do_cls) begin
         q_head <= '0;
         q_cnt  <= '0;
         q_lock <= 1'b0;
      end else begin
         if (err_valid_i && !q_lock) begin
            if (q_cnt == `SSR_QDEPTH && !rd_err) begin
               errq[wrap_idx(q_head, `SSR_QLAST)] <= `SSR_CODE_OVF;
               q_lock <= 1'b1;
            end else begin
               errq[wrap_idx(q_head, q_cnt - 5'(rd_err && q_cnt != '0))] <= err_code_i;
            end
         end
         if (rd_err && q_cnt != '0) begin
            q_head <= wrap_idx(q_head, 5'h01);
            q_lock <= 1'b0;
         end
         if (err_valid_i && !q_lock && q_cnt != `SSR_QDEPTH && !(rd_err && q_cnt != '0)) begin
            q_cnt <= q_cnt + 5'h01;
         end else if (!(err_valid_i && !q_lock) && rd_err && q_cnt != '0) begin
            q_cnt <= q_cnt - 5'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         error_indicator_o <= 1'b0;
         beep_o            <= 1'b0;
      end else begin
         error_indicator_o <= q_cnt != '0;
         beep_o            <= err_valid_i;
      end
   end

   // ****************************************
   // Command sequencer and output buffer
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state    <= ssr_pkg::SSR_IDLE;
         cmd_pend <= '0;
      end else begin
         case (state)
            ssr_pkg::SSR_IDLE: begin
               if (wr_en && paddr_i == `SSR_A_CMD) begin
                  cmd_pend <= pwdata_i[7:0];
                  state    <= (obuf_cnt == `SSR_OBUF_DEPTH) ? ssr_pkg::SSR_STALL
                                                            : ssr_pkg::SSR_EXEC;
               end
            end
            ssr_pkg::SSR_STALL: begin
               if (obuf_cnt != `SSR_OBUF_DEPTH) begin
                  state <= ssr_pkg::SSR_EXEC;
               end
            end
            ssr_pkg::SSR_EXEC: state <= ssr_pkg::SSR_IDLE;
            default:           state <= ssr_pkg::SSR_IDLE;
         endcase
      end
   end

   // Query results land in the output buffer
   logic [7:0] stbq_val;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         obuf_cnt <= '0;
         stbq_val <= '0;
      end else begin
         if (do_stbq) begin
            stbq_val <= stb;
         end
         if ((do_stbq || do_resp) && !(obuf_read_i && obuf_cnt != '0)) begin
            obuf_cnt <= obuf_cnt + 4'h1;
         end else if (!(do_stbq || do_resp) && obuf_read_i && obuf_cnt != '0) begin
            obuf_cnt <= obuf_cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cmd_busy_o <= 1'b0;
      end else begin
         cmd_busy_o <= state != ssr_pkg::SSR_IDLE || (wr_en && paddr_i == `SSR_A_CMD);
      end
   end

   // ****************************************
   // APB read path; one wait state per access
   // ****************************************
   always_comb begin
      next_rdata = '0;
      sel_idx    = out_sel(paddr_i, `SSR_A_SEVT1);
      case (paddr_i)
         `SSR_A_STB, `SSR_A_POLL: next_rdata[7:0] = stb;
         `SSR_A_SRE:  next_rdata[7:0]  = sre;
         `SSR_A_ESR:  next_rdata[7:0]  = esr;
         `SSR_A_ESE:  next_rdata[7:0]  = ese;
         `SSR_A_QEVT: next_rdata[15:0] = ques_full;
         `SSR_A_QENA: next_rdata[15:0] = qena;
         `SSR_A_IEVT: next_rdata[15:0] = ievt | inst_full;
         `SSR_A_IENA: next_rdata[15:0] = iena;
         `SSR_A_ERR:  next_rdata[15:0] = (q_cnt == '0) ? `SSR_CODE_NONE
                                                       : errq[q_head];
         `SSR_A_STAT: next_rdata[8:0]  = {q_lock, stbq_val};
         `SSR_A_OBUF: next_rdata[3:0]  = obuf_cnt;
         default: begin
            if (paddr_i >= `SSR_A_SEVT1 && paddr_i < `SSR_A_SENA1) begin
               next_rdata[15:0] = sevt[sel_idx];
            end else if (paddr_i >= `SSR_A_SENA1 && paddr_i < `SSR_A_COND1) begin
               next_rdata[15:0] = sena[out_sel(paddr_i, `SSR_A_SENA1)];
            end else if (paddr_i >= `SSR_A_COND1 && paddr_i < `SSR_A_ERR) begin
               next_rdata[1:0] = out_cond_i[out_sel(paddr_i, `SSR_A_COND1)];
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= '0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i && penable_i && !pready_o;
         prdata_o  <= next_rdata;
         pslverr_o <= psel_i && penable_i && !pready_o &&
                      (paddr_i > `SSR_A_OBUF || paddr_i[1:0] != 2'b00);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_poll_clears_rqs: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_poll && !(rqs_cond && !rqs_cond_d) |=> !rqs)
      else $error("request bit survived a poll");
   chk_rqs_needs_enable: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(rqs) |-> $past(rqs_cond))
      else $error("request raised without enabled summary");
   chk_srq_follows: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(rqs) |=> service_request_o)
      else $error("service request did not follow");
   chk_stbq_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
      do_stbq && rqs && rqs_cond && !rd_poll |=> rqs)
      else $error("byte query cleared request");
   chk_mav_level: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(stb[`SSR_B_MAV]) |-> $past(obuf_read_i) && $past(obuf_cnt) == 4'h1)
      else $error("message available wrong");
   chk_opc_sets: assert property (@(posedge clk_i) disable iff (srst_i)
      do_opc |=> esr[`SSR_B_OPC])
      else $error("operation complete not set");
   chk_queue_bound: assert property (@(posedge clk_i) disable iff (srst_i)
      q_cnt <= `SSR_QDEPTH)
      else $error("error queue overran");
   chk_cls_empties: assert property (@(posedge clk_i) disable iff (srst_i)
      do_cls |=> q_cnt == 5'h00 && !q_lock)
      else $error("clear left errors");
   chk_stall_full: assert property (@(posedge clk_i) disable iff (srst_i)
      state == ssr_pkg::SSR_STALL && obuf_cnt == `SSR_OBUF_DEPTH |=> state == ssr_pkg::SSR_STALL)
      else $error("command ran while output buffer full");

endmodule : ssr_unit
`default_nettype wire

// [tb/ssr_ctrl_model.sv]
// Bus controller side: reads queued response messages out of the device.
// Assumes the bench says how many to read and whether to pace slowly.
`timescale 1ns/10ps
`default_nettype none
module ssr_ctrl_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // Requests from the bench
   input  wire logic       req_i,
   input  wire logic [3:0] cnt_i,
   input  wire logic       slow_i,
   // Towards the device; busy_o back to the bench
   output logic            obuf_read_o,
   output logic            busy_o
);
   logic [3:0] left;
   logic [2:0] gap;
   // Slow pacing leaves gaps so the device sees reads trickle in
   always_ff @(posedge clk_i) begin
      obuf_read_o <= 1'b0;
      if (srst_i) begin
         left <= 4'h0;
         gap  <= 3'h0;
      end else if (req_i) begin
         left <= cnt_i;
         gap  <= 3'h0;
      end else if (left != 4'h0) begin
         if (gap == 3'h0) begin
            obuf_read_o <= 1'b1;
            left        <= left - 4'h1;
            gap         <= slow_i ? 3'h4 : 3'h0;
         end else begin
            gap <= gap - 3'h1;
         end
      end
   end
   assign busy_o = (left != 4'h0) | req_i;
endmodule : ssr_ctrl_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the status and service-request unit.
// Assumes the register map and command codes of ssr_params.svh.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_params.svh"
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic                clk_i = 1'b0;
   logic                srst_i = 1'b1;
   logic                psel_i = 1'b0;
   logic                penable_i = 1'b0;
   logic                pwrite_i = 1'b0;
   logic [11:0]         paddr_i = 12'h000;
   logic [31:0]         pwdata_i = 32'h0;
   logic [31:0]         prdata_o;
   logic                pready_o;
   logic                pslverr_o;
   logic [7:0]          std_event_i = 8'h00;
   logic [15:0]         ques_event_i = 16'h0000;
   logic [2:0][15:0]    out_event_i = '0;
   logic [2:0][1:0]     out_cond_i = '0;
   logic                err_valid_i = 1'b0;
   logic [15:0]         err_code_i = 16'h0000;
   logic                obuf_read_i;
   logic                service_request_o;
   logic                error_indicator_o;
   logic                beep_o;
   logic                cmd_busy_o;
   logic                req = 1'b0;
   logic [3:0]          cnt = 4'h0;
   logic                slow = 1'b0;
   logic                pbusy;
   int                  n_mismatch = 0;
   int                  num_checks = 0;
   int                  n_beep = 0;
   int                  cyc = 0;

   always #5 clk_i = ~clk_i;

   ssr_unit i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .std_event_i(std_event_i),
      .ques_event_i(ques_event_i), .out_event_i(out_event_i), .out_cond_i(out_cond_i),
      .err_valid_i(err_valid_i), .err_code_i(err_code_i), .obuf_read_i(obuf_read_i),
      .service_request_o(service_request_o), .error_indicator_o(error_indicator_o),
      .beep_o(beep_o), .cmd_busy_o(cmd_busy_o));

   ssr_ctrl_model i_ctrl (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .cnt_i(cnt),
      .slow_i(slow), .obuf_read_o(obuf_read_i), .busy_o(pbusy));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic tally_and_finish();
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) chk(32'h0, 32'h1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd

   // Error codes are 16 bits; the unit returns the upper bits as zero
   task automatic rde(input logic [15:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, `SSR_A_ERR, 32'h0, r, e);
      chk({16'h0000, r[15:0]}, {16'h0000, x});
   endtask : rde

   task automatic idle();
      int n;
      repeat (2) @(posedge clk_i);
      for (n = 0; n < 50 && cmd_busy_o !== 1'b0; n++) @(posedge clk_i);
      chk({31'h0, cmd_busy_o}, 32'h0);
      repeat (2) @(posedge clk_i);
   endtask : idle

   task automatic cmd(input logic [7:0] c);
      wr(`SSR_A_CMD, {24'h0, c});
      idle();
   endtask : cmd

   task automatic ev(input logic [7:0] s, input logic [15:0] q, input logic [15:0] o0,
                     input logic [15:0] o1);
      @(posedge clk_i);
      std_event_i    <= s;
      ques_event_i   <= q;
      out_event_i[0] <= o0;
      out_event_i[1] <= o1;
      @(posedge clk_i);
      std_event_i  <= 8'h00;
      ques_event_i <= 16'h0000;
      out_event_i  <= '0;
   endtask : ev

   task automatic err(input logic [15:0] c);
      @(posedge clk_i);
      err_valid_i <= 1'b1;
      err_code_i  <= c;
      @(posedge clk_i);
      err_valid_i <= 1'b0;
   endtask : err

   task automatic drain(input logic [3:0] n, input logic s);
      int k;
      @(posedge clk_i);
      req  <= 1'b1;
      cnt  <= n;
      slow <= s;
      @(posedge clk_i);
      req <= 1'b0;
      for (k = 0; k < 100 && pbusy === 1'b1; k++) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
   endtask : drain

   always @(posedge clk_i) begin
      if (beep_o === 1'b1) n_beep++;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] r;
      logic        e;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(`SSR_A_STB, 32'h00);
      rd(`SSR_A_ESR, 32'h80);
      rd(`SSR_A_ESR, 32'h00);
      wr(`SSR_A_ESE, 32'h01);
      wr(`SSR_A_SRE, 32'h20);
      cmd(`SSR_CMD_OPC);
      chk({31'h0, service_request_o}, 32'h1);
      rd(`SSR_A_STB, 32'h60);
      rd(`SSR_A_POLL, 32'h60);
      rd(`SSR_A_STB, 32'h20);
      chk({31'h0, service_request_o}, 32'h0);
      rd(`SSR_A_ESR, 32'h01);
      cmd(`SSR_CMD_OPC);
      rd(`SSR_A_STB, 32'h60);
      rd(`SSR_A_ESR, 32'h01);
      rd(`SSR_A_STB, 32'h00);
      chk({31'h0, service_request_o}, 32'h0);
      cmd(`SSR_CMD_OPC);
      cmd(`SSR_CMD_STBQ);
      rd(`SSR_A_STAT, 32'h60);
      rd(`SSR_A_POLL, 32'h70);
      rd(`SSR_A_STB, 32'h30);
      rd(`SSR_A_OBUF, 32'h1);
      drain(4'h1, 1'b1);
      rd(`SSR_A_STB, 32'h20);
      rd(`SSR_A_ESR, 32'h01);
      wr(`SSR_A_SRE, 32'h00);
      wr(`SSR_A_ESE, 32'h20);
      ev(8'h20, 16'h0, 16'h0, 16'h0);
      rd(`SSR_A_STB, 32'h20);
      chk({31'h0, service_request_o}, 32'h0);
      rd(`SSR_A_ESR, 32'h20);
      wr(`SSR_A_QENA, 32'h04);
      ev(8'h00, 16'h0008, 16'h0, 16'h0);
      rd(`SSR_A_STB, 32'h00);
      ev(8'h00, 16'h0004, 16'h0, 16'h0);
      rd(`SSR_A_STB, 32'h08);
      rd(`SSR_A_QEVT, 32'h0C);
      rd(`SSR_A_STB, 32'h00);
      wr(`SSR_A_SENA1, 32'h0001);
      wr(`SSR_A_IENA, 32'h0002);
      ev(8'h00, 16'h0, 16'h0001, 16'h0001);
      rd(`SSR_A_QEVT, 32'h2000);
      rd(`SSR_A_SEVT1 + 12'h004, 32'h0001);
      rd(`SSR_A_IEVT, 32'h0002);
      rd(`SSR_A_SEVT1, 32'h0001);
      rd(`SSR_A_SEVT1, 32'h0000);
      for (int v = 0; v < 4; v++) begin
         for (int k = 0; k < 3; k++) begin
            out_cond_i[k] <= 2'(v);
            rd(`SSR_A_COND1 + 12'(4 * k), 32'(v));
         end
      end
      repeat (8) wr(`SSR_A_CMD, {24'h0, `SSR_CMD_RESP});
      idle();
      rd(`SSR_A_OBUF, 32'h8);
      wr(`SSR_A_ESE, 32'h01);
      wr(`SSR_A_CMD, {24'h0, `SSR_CMD_OPC});
      repeat (6) @(posedge clk_i);
      chk({31'h0, cmd_busy_o}, 32'h1);
      rd(`SSR_A_ESR, 32'h00);
      drain(4'h1, 1'b1);
      idle();
      rd(`SSR_A_ESR, 32'h01);
      rd(`SSR_A_STB, 32'h10);
      drain(4'h7, 1'b0);
      rd(`SSR_A_STB, 32'h00);
      err(16'hFF9C);
      err(16'h0258);
      err(16'hFF2E);
      chk({31'h0, error_indicator_o}, 32'h1);
      rde(16'hFF9C);
      rde(16'h0258);
      rde(16'hFF2E);
      repeat (2) @(posedge clk_i);
      chk({31'h0, error_indicator_o}, 32'h0);
      rde(`SSR_CODE_NONE);
      for (int i = 0; i < 22; i++) err(16'h0100 + 16'(i));
      for (int i = 0; i < 19; i++) rde(16'h0100 + 16'(i));
      rde(`SSR_CODE_OVF);
      rde(`SSR_CODE_NONE);
      err(16'h0111);
      err(16'h0222);
      ev(8'h08, 16'h0004, 16'h0, 16'h0);
      cmd(`SSR_CMD_RST);
      chk({31'h0, error_indicator_o}, 32'h1);
      cmd(`SSR_CMD_CLS);
      chk({31'h0, error_indicator_o}, 32'h0);
      rde(`SSR_CODE_NONE);
      rd(`SSR_A_ESR, 32'h00);
      rd(`SSR_A_QEVT, 32'h00);
      rd(`SSR_A_STB, 32'h00);
      apb(1'b0, 12'h0FC, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(32'(n_beep), 32'd27);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
